// File: pdft_map.vh
`ifndef PDFT_MAP_VH
`define PDFT_MAP_VH
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define PDFT_ADDR_DROP_EN   8'h13
`define PDFT_ADDR_DET_CLS   8'h14
`define PDFT_ADDR_PRIO      8'h15
`define PDFT_ADDR_TIMING    8'h16
// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define PDFT_LIM_MSB        7
`define PDFT_LIM_LSB        6
`define PDFT_INR_MSB        5
`define PDFT_INR_LSB        4
`define PDFT_CUT_MSB        3
`define PDFT_CUT_LSB        2
`define PDFT_DROP_MSB       1
`define PDFT_DROP_LSB       0
`define PDFT_TIMING_RESET   8'h00
`define PDFT_PRIO_RSVD_RST  4'h0
// ---------------------------------------------------------------
// port modes
// ---------------------------------------------------------------
`define PDFT_MODE_OFF       2'h0
`define PDFT_MODE_MANUAL    2'h1
`define PDFT_MODE_SEMI      2'h2
`define PDFT_MODE_AUTO      2'h3
// ---------------------------------------------------------------
// timing, in ms unless named otherwise
// ---------------------------------------------------------------
`define PDFT_CLK_PERIOD_NS  8
`define PDFT_MS_NS          1000000
`define PDFT_UP_DIV         4'hf
`define PDFT_RECOVER_PCT    17'h0000d
`define PDFT_T_60           10'h03c
`define PDFT_T_30           10'h01e
`define PDFT_T_15           10'h00f
`define PDFT_T_10           10'h00a
`define PDFT_T_90           10'h05a
`define PDFT_T_120          10'h078
`define PDFT_T_180          10'h0b4
`define PDFT_T_240          10'h0f0
`define PDFT_T_360          10'h168
`define PDFT_T_720          10'h2d0
`endif

// File: pdft_port.v
`timescale 1ns/1ps
`include "pdft_map.vh"
module pdft_port (
	// clock, reset and time base
	input  wire        core_clk_i,
	input  wire        reset_n_i,
	input  wire        tick_ms_i,
	input  wire        tick_up_i,
	// configuration
	input  wire [1:0]  mode_i,
	input  wire        det_en_i,
	input  wire        cls_en_i,
	input  wire        drop_en_i,
	input  wire [7:0]  timing_i,
	input  wire        high_power_i,
	input  wire [11:0] cooldown_ms_i,
	// synchronised comparators
	input  wire        below_drop_i,
	input  wire        above_cut_i,
	input  wire        limiting_i,
	input  wire        inrush_lim_i,
	input  wire        pg_i,
	// commands
	input  wire        pwr_on_cmd_i,
	input  wire        off_req_i,
	input  wire        off_cmd_i,
	// detect and class engine
	input  wire        det_done_i,
	input  wire        det_valid_i,
	input  wire        cls_done_i,
	input  wire        cls_bad_i,
	// outputs
	output reg         det_start_o,
	output reg         cls_start_o,
	output reg         det_clr_o,
	output reg         cls_clr_o,
	output reg         power_on_o,
	output reg         power_good_o,
	output reg         drop_fault_o,
	output reg         cooling_o,
	output reg         fault_inr_o,
	output reg         fault_cut_o,
	output reg         fault_lim_o
);
	localparam S_IDLE = 3'h0;
	localparam S_DET  = 3'h1;
	localparam S_CLS  = 3'h2;
	localparam S_INR  = 3'h3;
	localparam S_ON   = 3'h4;
	localparam S_COOL = 3'h5;

	reg  [2:0]  state;
	reg  [11:0] tmr;
	reg  [9:0]  lim_t;
	reg  [9:0]  cut_t;
	reg  [9:0]  drop_t;
	reg  [9:0]  above_t;
	reg  [9:0]  lim_max;
	reg  [9:0]  inr_max;
	reg  [9:0]  cut_max;
	reg  [9:0]  drop_max;
	wire [16:0] rec_x;
	wire [16:0] rec_q;
	wire        manual;
	wire        kill;
	wire        drop_hit;

	// ---------------------------------------------------------------
	// time selections
	// ---------------------------------------------------------------
	always @* begin
		if (!high_power_i)
			lim_max = `PDFT_T_60;
		else case (timing_i[`PDFT_LIM_MSB:`PDFT_LIM_LSB])
			2'h0:    lim_max = `PDFT_T_60;
			2'h1:    lim_max = `PDFT_T_30;
			2'h2:    lim_max = `PDFT_T_15;
			default: lim_max = `PDFT_T_10;
		endcase
		case (timing_i[`PDFT_INR_MSB:`PDFT_INR_LSB])
			2'h1:    inr_max = `PDFT_T_30;
			2'h2:    inr_max = `PDFT_T_120;
			default: inr_max = `PDFT_T_60; // reserved code behaves as default
		endcase
		case (timing_i[`PDFT_CUT_MSB:`PDFT_CUT_LSB])
			2'h0:    cut_max = `PDFT_T_60;
			2'h1:    cut_max = `PDFT_T_30;
			2'h2:    cut_max = `PDFT_T_120;
			default: cut_max = `PDFT_T_240;
		endcase
		case (timing_i[`PDFT_DROP_MSB:`PDFT_DROP_LSB])
			2'h0:    drop_max = `PDFT_T_360;
			2'h1:    drop_max = `PDFT_T_90;
			2'h2:    drop_max = `PDFT_T_180;
			default: drop_max = `PDFT_T_720;
		endcase
	end

	// recovery window, a least time so it rounds up
	assign rec_x    = {7'h00, drop_max} * `PDFT_RECOVER_PCT + 17'h00063;
	assign rec_q    = rec_x / 17'h00064;
	assign manual   = (mode_i == `PDFT_MODE_MANUAL);
	assign kill     = off_req_i | (mode_i == `PDFT_MODE_OFF);
	assign drop_hit = drop_en_i & below_drop_i & tick_ms_i & (drop_t <= 10'h001);

	// ---------------------------------------------------------------
	// port sequencer and fault timers
	// ---------------------------------------------------------------
	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state <= S_IDLE;
			tmr <= 12'h000;
			lim_t <= 10'h000;
			cut_t <= 10'h000;
			drop_t <= 10'h000;
			above_t <= 10'h000;
			det_start_o <= 1'b0;
			cls_start_o <= 1'b0;
			det_clr_o <= 1'b0;
			cls_clr_o <= 1'b0;
			power_on_o <= 1'b0;
			power_good_o <= 1'b0;
			drop_fault_o <= 1'b0;
			cooling_o <= 1'b0;
			fault_inr_o <= 1'b0;
			fault_cut_o <= 1'b0;
			fault_lim_o <= 1'b0;
		end else begin
			det_start_o <= 1'b0;
			cls_start_o <= 1'b0;
			det_clr_o <= 1'b0;
			cls_clr_o <= 1'b0;
			fault_inr_o <= 1'b0;
			fault_cut_o <= 1'b0;
			fault_lim_o <= 1'b0;
			cooling_o <= (state == S_COOL);
			if (state == S_INR || state == S_ON)
				power_good_o <= power_good_o | pg_i;
			// the clearing command also kills the port, so the clear wins over a timeout in the same cycle
			if (state == S_ON && !kill && drop_hit)
				drop_fault_o <= 1'b1;
			else if (off_cmd_i)
				drop_fault_o <= 1'b0;
			case (state)
			S_IDLE: begin
				if (kill) begin
					state <= S_IDLE;
				end else if (pwr_on_cmd_i) begin
					state <= S_INR;
					tmr <= 12'h000;
					power_on_o <= 1'b1;
				end else if (!manual && det_en_i && cls_en_i) begin
					state <= S_DET;
					det_start_o <= 1'b1;
				end else if (manual && det_en_i) begin
					state <= S_DET;
					det_start_o <= 1'b1;
				end else if (manual && cls_en_i) begin
					state <= S_CLS;
					cls_start_o <= 1'b1;
				end
			end
			S_DET: begin
				if (kill) begin
					state <= S_IDLE;
				end else if (det_done_i) begin
					if (manual) begin
						det_clr_o <= 1'b1;
						state <= S_IDLE;
					end else if (det_valid_i) begin
						state <= S_CLS;
						cls_start_o <= 1'b1;
					end else begin
						state <= S_IDLE; // class skipped
					end
				end
			end
			S_CLS: begin
				if (kill) begin
					state <= S_IDLE;
				end else if (cls_done_i) begin
					cls_clr_o <= manual;
					if (mode_i == `PDFT_MODE_AUTO && !cls_bad_i) begin
						state <= S_INR;
						tmr <= 12'h000;
						power_on_o <= 1'b1;
					end else begin
						state <= S_IDLE;
					end
				end
			end
			S_INR: begin
				if (kill) begin
					state <= S_IDLE;
					power_on_o <= 1'b0;
					power_good_o <= 1'b0;
				end else if (tmr >= {2'h0, inr_max}) begin
					if (inrush_lim_i) begin
						state <= S_COOL;
						tmr <= 12'h000;
						power_on_o <= 1'b0;
						power_good_o <= 1'b0;
						fault_inr_o <= 1'b1;
					end else begin
						state <= S_ON;
						lim_t <= lim_max;
						cut_t <= cut_max;
						drop_t <= drop_max;
						above_t <= 10'h000;
					end
				end else if (tick_ms_i) begin
					tmr <= tmr + 12'h001;
				end
			end
			S_ON: begin
				if (kill) begin
					state <= S_IDLE;
					power_on_o <= 1'b0;
					power_good_o <= 1'b0;
				end else if (tick_ms_i && limiting_i && lim_t <= 10'h001) begin
					state <= S_COOL;
					tmr <= 12'h000;
					power_on_o <= 1'b0;
					power_good_o <= 1'b0;
					fault_lim_o <= 1'b1;
				end else if (tick_ms_i && above_cut_i && cut_t <= 10'h001) begin
					state <= S_COOL;
					tmr <= 12'h000;
					power_on_o <= 1'b0;
					power_good_o <= 1'b0;
					fault_cut_o <= 1'b1;
				end else if (drop_hit) begin
					state <= S_IDLE;
					power_on_o <= 1'b0;
					power_good_o <= 1'b0;
				end else if (tick_ms_i) begin
					if (limiting_i)
						lim_t <= lim_t - 10'h001;
					else if (tick_up_i && lim_t < lim_max)
						lim_t <= lim_t + 10'h001;
					if (above_cut_i)
						cut_t <= cut_t - 10'h001;
					else if (tick_up_i && cut_t < cut_max)
						cut_t <= cut_t + 10'h001;
					// never counts below zero, reloads after a steady recovery
					if (!drop_en_i || !below_drop_i) begin
						if (above_t + 10'h001 >= rec_q[9:0]) begin
							drop_t <= drop_max;
							above_t <= 10'h000;
						end else begin
							above_t <= above_t + 10'h001;
						end
					end else begin
						above_t <= 10'h000;
						drop_t <= drop_t - 10'h001;
					end
				end
			end
			S_COOL: begin
				// enables stay stored and are acted on once this ends
				if (tmr >= cooldown_ms_i) begin
					state <= S_IDLE;
				end else if (!kill && manual && pwr_on_cmd_i) begin
					state <= S_INR;
					tmr <= 12'h000;
					power_on_o <= 1'b1;
				end else if (tick_ms_i) begin
					tmr <= tmr + 12'h001;
				end
			end
			default: state <= S_IDLE;
			endcase
		end
	end
endmodule

// File: pdft_core.v
`timescale 1ns/1ps
`include "pdft_map.vh"
// Summary of operation
// - enabled dropout timer runs while current is low, timeout powers off, flags fault.
// - dropout timer starts after inrush, reloads after steady 13% recovery, floors zero.
// - dropout delay field picks 360, 90, 180 or 720 ms.
// - manual mode runs one detect or class cycle, then clears that enable.
// - a power-off command clears that port's detect and class enables.
// - semi-auto repeats detection, classifies only after a valid detection.
// - auto mode classifies after valid detection, then powers unless class is bad.
// - during cool-down detect and class enables wait until cool-down ends.
// - after cool-down semi and auto restart detection if detect and class enables are both set.
// - low fast-off pin powers off every port with its priority bit set.
// - inrush, overload or limit faults clear power-good and power-on flags.
// - limit timer loads after inrush, counts down while limiting, zero starts cool-down.
// - below limit the limit timer counts up at 1/16 rate, saturating.
// - limit time is 60 ms unless high-power, then field picks 60/30/15/10.
// - still inrush-limited after inrush time means power off and cool-down.
// - overload timer loads after inrush, counts down above cut, up at 1/16.
// - overload field picks 60, 30, 120 or 240 ms.
// - one shared timing register, reset zero, holds four two-bit fields.
// - port mode codes are off, manual, semi-automatic and automatic.
// - strap-dependent reset values load only after power-on or reset input.
module pdft_core #(
	parameter TICK_CYCLES = `PDFT_MS_NS / `PDFT_CLK_PERIOD_NS
) (
	// clock and reset
	input  wire        core_clk_i,
	input  wire        reset_n_i,
	// register command port
	input  wire        reg_wr_i,
	input  wire [7:0]  reg_addr_i,
	input  wire [7:0]  reg_wdata_i,
	output reg  [7:0]  reg_rdata_o,
	// settings held elsewhere in the device
	input  wire [7:0]  mode_i,
	input  wire [3:0]  high_power_port_flag_i,
	input  wire [11:0] cooldown_ms_i,
	input  wire        auto_strap_i,
	// push-button commands, one cycle each
	input  wire [3:0]  power_on_cmd_i,
	input  wire [3:0]  power_off_cmd_i,
	input  wire [3:0]  port_reset_i,
	// pins and analog comparators
	input  wire        fast_off_pin_n_i,
	input  wire [3:0]  below_dropout_i,
	input  wire [3:0]  above_cut_i,
	input  wire [3:0]  limiting_i,
	input  wire [3:0]  inrush_limiting_i,
	input  wire [3:0]  drain_good_i,
	// detection and classification engine
	input  wire [3:0]  detect_done_i,
	input  wire [3:0]  detect_valid_i,
	input  wire [3:0]  class_done_i,
	input  wire [3:0]  class_bad_i,
	output wire [3:0]  detect_start_o,
	output wire [3:0]  class_start_o,
	// port status
	output wire [3:0]  power_on_flag_o,
	output wire [3:0]  power_good_flag_o,
	output wire [3:0]  dropout_fault_flag_o,
	output wire [3:0]  cooldown_active_o,
	output wire [3:0]  fault_inrush_o,
	output wire [3:0]  fault_overload_o,
	output wire [3:0]  fault_limit_o
);
	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	reg  [21:0] sync_a;
	reg  [21:0] sync_b;
	reg  [16:0] tick_cnt;
	reg  [3:0]  up_cnt;
	reg         tick_ms;
	reg         tick_up;
	reg  [1:0]  init_cnt;
	reg  [3:0]  dropout_check_enable;
	reg  [3:0]  detect_enable;
	reg  [3:0]  class_enable;
	reg  [3:0]  fast_off_priority;
	reg  [3:0]  prio_rsvd;
	reg  [7:0]  fault_timing_config;
	reg  [7:0]  next_rdata;
	wire [3:0]  s_below;
	wire [3:0]  s_cut;
	wire [3:0]  s_lim;
	wire [3:0]  s_inr;
	wire [3:0]  s_pg;
	wire        s_pin_n;
	wire        s_strap;
	wire [3:0]  off_req;
	wire [3:0]  det_clr;
	wire [3:0]  cls_clr;
	wire        wr_det_cls;
	wire        init_load;
	wire [3:0]  strap_fill;

	// ---------------------------------------------------------------
	// input synchronisers
	// ---------------------------------------------------------------
	// every pin and comparator crosses in; only the second stage is read
	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sync_a <= 22'h300000;
			sync_b <= 22'h300000;
		end else begin
			sync_a <= {auto_strap_i, fast_off_pin_n_i, drain_good_i, inrush_limiting_i,
				limiting_i, above_cut_i, below_dropout_i};
			sync_b <= sync_a;
		end
	end

	assign s_below = sync_b[3:0];
	assign s_cut   = sync_b[7:4];
	assign s_lim   = sync_b[11:8];
	assign s_inr   = sync_b[15:12];
	assign s_pg    = sync_b[19:16];
	assign s_pin_n = sync_b[20];
	assign s_strap = sync_b[21];

	// ---------------------------------------------------------------
	// millisecond time base
	// ---------------------------------------------------------------
	// one shared divider keeps all port timers in step; the slow up-count
	// is every sixteenth tick
	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tick_cnt <= 17'h00000;
			up_cnt <= 4'h0;
			tick_ms <= 1'b0;
			tick_up <= 1'b0;
		end else begin
			tick_ms <= 1'b0;
			tick_up <= 1'b0;
			if (tick_cnt >= TICK_CYCLES[16:0] - 17'h00001) begin
				tick_cnt <= 17'h00000;
				tick_ms <= 1'b1;
				up_cnt <= up_cnt + 4'h1;
				tick_up <= (up_cnt == `PDFT_UP_DIV);
			end else begin
				tick_cnt <= tick_cnt + 17'h00001;
			end
		end
	end

	// ---------------------------------------------------------------
	// strap capture after reset release
	// ---------------------------------------------------------------
	// wait two edges so the synchronised strap is settled before use
	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			init_cnt <= 2'h0;
		else if (init_cnt != 2'h3)
			init_cnt <= init_cnt + 2'h1;
	end

	assign init_load  = (init_cnt == 2'h2);
	assign strap_fill = {4{s_strap}};

	// ---------------------------------------------------------------
	// register writes
	// ---------------------------------------------------------------
	assign wr_det_cls = reg_wr_i && (reg_addr_i == `PDFT_ADDR_DET_CLS);
	// fast-off acts like a port reset, held for as long as the pin is low
	assign off_req = power_off_cmd_i | port_reset_i |
		(fast_off_priority & {4{~s_pin_n}});

	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dropout_check_enable <= 4'h0;
			detect_enable <= 4'h0;
			class_enable <= 4'h0;
			fast_off_priority <= 4'h0;
			prio_rsvd <= `PDFT_PRIO_RSVD_RST;
			fault_timing_config <= `PDFT_TIMING_RESET;
		end else if (init_load) begin
			dropout_check_enable <= strap_fill;
			detect_enable <= strap_fill;
			class_enable <= strap_fill;
			fast_off_priority <= strap_fill;
		end else begin
			if (reg_wr_i && reg_addr_i == `PDFT_ADDR_DROP_EN)
				dropout_check_enable <= reg_wdata_i[3:0];
			if (reg_wr_i && reg_addr_i == `PDFT_ADDR_PRIO) begin
				fast_off_priority <= reg_wdata_i[7:4];
				prio_rsvd <= reg_wdata_i[3:0];
			end
			if (reg_wr_i && reg_addr_i == `PDFT_ADDR_TIMING)
				fault_timing_config <= reg_wdata_i;
			// a host write wins over a same-cycle hardware clear
			if (wr_det_cls) begin
				detect_enable <= reg_wdata_i[3:0];
				class_enable <= reg_wdata_i[7:4];
			end else begin
				detect_enable <= detect_enable & ~det_clr & ~power_off_cmd_i;
				class_enable <= class_enable & ~cls_clr & ~power_off_cmd_i;
			end
		end
	end

	// ---------------------------------------------------------------
	// register reads
	// ---------------------------------------------------------------
	// data is registered, so it follows the address one cycle later
	always @* begin
		case (reg_addr_i)
			`PDFT_ADDR_DROP_EN: next_rdata = {4'h0, dropout_check_enable};
			`PDFT_ADDR_DET_CLS: next_rdata = {class_enable, detect_enable};
			`PDFT_ADDR_PRIO:    next_rdata = {fast_off_priority, prio_rsvd};
			`PDFT_ADDR_TIMING:  next_rdata = fault_timing_config;
			default:            next_rdata = 8'h00;
		endcase
	end

	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			reg_rdata_o <= 8'h00;
		else
			reg_rdata_o <= next_rdata;
	end

	// ---------------------------------------------------------------
	// per-port controllers
	// ---------------------------------------------------------------
	genvar p;
	generate
		for (p = 0; p < 4; p = p + 1) begin : g_port
			pdft_port u_port (
				.core_clk_i    (core_clk_i),
				.reset_n_i     (reset_n_i),
				.tick_ms_i     (tick_ms),
				.tick_up_i     (tick_up),
				.mode_i        (mode_i[2*p+1:2*p]),
				.det_en_i      (detect_enable[p]),
				.cls_en_i      (class_enable[p]),
				.drop_en_i     (dropout_check_enable[p]),
				.timing_i      (fault_timing_config),
				.high_power_i  (high_power_port_flag_i[p]),
				.cooldown_ms_i (cooldown_ms_i),
				.below_drop_i  (s_below[p]),
				.above_cut_i   (s_cut[p]),
				.limiting_i    (s_lim[p]),
				.inrush_lim_i  (s_inr[p]),
				.pg_i          (s_pg[p]),
				.pwr_on_cmd_i  (power_on_cmd_i[p] & ~power_off_cmd_i[p]),
				.off_req_i     (off_req[p]),
				.off_cmd_i     (power_off_cmd_i[p]),
				.det_done_i    (detect_done_i[p]),
				.det_valid_i   (detect_valid_i[p]),
				.cls_done_i    (class_done_i[p]),
				.cls_bad_i     (class_bad_i[p]),
				.det_start_o   (detect_start_o[p]),
				.cls_start_o   (class_start_o[p]),
				.det_clr_o     (det_clr[p]),
				.cls_clr_o     (cls_clr[p]),
				.power_on_o    (power_on_flag_o[p]),
				.power_good_o  (power_good_flag_o[p]),
				.drop_fault_o  (dropout_fault_flag_o[p]),
				.cooling_o     (cooldown_active_o[p]),
				.fault_inr_o   (fault_inrush_o[p]),
				.fault_cut_o   (fault_overload_o[p]),
				.fault_lim_o   (fault_limit_o[p])
			);
		end
	endgenerate
endmodule

// File: pdft_asserts.sv
`timescale 1ns/1ps
module pdft_asserts (
	// clock, reset and register port
	input wire       core_clk_i,
	input wire       reset_n_i,
	input wire       reg_wr_i,
	input wire [7:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire [7:0] reg_rdata_o,
	// commands and engine answers
	input wire [7:0] mode_i,
	input wire [3:0] power_on_cmd_i,
	input wire [3:0] power_off_cmd_i,
	input wire [3:0] detect_done_i,
	input wire [3:0] detect_valid_i,
	input wire [3:0] class_done_i,
	// watched outputs
	input wire [3:0] class_start_o,
	input wire [3:0] power_on_flag_o,
	input wire [3:0] power_good_flag_o,
	input wire [3:0] dropout_fault_flag_o,
	input wire [3:0] cooldown_active_o,
	input wire [3:0] fault_inrush_o
);
	// ----------
	// port 0 stands for all four lanes
	// ----------
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	unmapped_read_a: assert property (
		(reg_addr_i < 8'h13 || reg_addr_i > 8'h16) |=> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	drop_nibble_a: assert property (
		reg_addr_i == 8'h13 |=> reg_rdata_o[7:4] == 4'h0)
		else $error("dropout enable high nibble not zero");
	timing_store_a: assert property (
		reg_wr_i && reg_addr_i == 8'h16 ##1 !reg_wr_i && reg_addr_i == 8'h16
		|=> reg_rdata_o == $past(reg_wdata_i, 2))
		else $error("timing register lost write");
	off_cmd_a: assert property (
		power_off_cmd_i[0] |=> !power_on_flag_o[0])
		else $error("power off command ignored");
	on_cause_a: assert property (
		$rose(power_on_flag_o[0]) |-> $past(power_on_cmd_i[0] || class_done_i[0]))
		else $error("power on without cause");
	class_after_a: assert property (
		class_start_o[0] && mode_i[1:0] != 2'h1
		|-> $past(detect_done_i[0] && detect_valid_i[0]))
		else $error("class without valid detect");
	fault_clears_a: assert property (
		fault_inrush_o[0] |-> ##[0:1] !power_on_flag_o[0] && !power_good_flag_o[0])
		else $error("inrush fault left port flags");
	fault_cool_a: assert property (
		fault_inrush_o[0] |-> ##[0:1] cooldown_active_o[0])
		else $error("inrush fault without cool-down");
	drop_off_a: assert property (
		$rose(dropout_fault_flag_o[0]) |-> ##[0:1] !power_on_flag_o[0])
		else $error("dropout flag with port on");
endmodule
bind pdft_core pdft_asserts pdft_asserts_inst (.core_clk_i, .reset_n_i, .reg_wr_i,
	.reg_addr_i, .reg_wdata_i, .reg_rdata_o, .mode_i, .power_on_cmd_i, .power_off_cmd_i,
	.detect_done_i, .detect_valid_i, .class_done_i, .class_start_o, .power_on_flag_o,
	.power_good_flag_o, .dropout_fault_flag_o, .cooldown_active_o, .fault_inrush_o);

// File: pdft_eng_model.sv
`timescale 1ns/1ps
module pdft_eng_model #(
	parameter LAT = 8
) (
	// clock and starts
	input  wire       core_clk_i,
	input  wire [3:0] detect_start_i,
	input  wire [3:0] class_start_i,
	input  wire       valid_sel_i,
	// answers
	output reg  [3:0] detect_done_o,
	output wire [3:0] detect_valid_o,
	output reg  [3:0] class_done_o,
	output wire [3:0] class_bad_o
);
	reg     [7:0] dc [0:3];
	reg     [7:0] cc [0:3];
	reg           flip;
	integer       k;
	// idle state, nothing in flight
	initial begin
		detect_done_o = 4'h0;
		class_done_o = 4'h0;
		flip = 1'b0;
		for (k = 0; k < 4; k = k + 1) begin
			dc[k] = 8'h00;
			cc[k] = 8'h00;
		end
	end
	// fixed latency per cycle, a done pulse at the end
	always @(posedge core_clk_i) begin
		flip <= ~flip;
		for (k = 0; k < 4; k = k + 1) begin
			detect_done_o[k] <= (dc[k] == 8'h01);
			class_done_o[k] <= (cc[k] == 8'h01);
			dc[k] <= detect_start_i[k] ? LAT[7:0] : (dc[k] != 8'h00 ? dc[k] - 8'h01 : 8'h00);
			cc[k] <= class_start_i[k] ? LAT[7:0] : (cc[k] != 8'h00 ? cc[k] - 8'h01 : 8'h00);
		end
	end
	// qualifiers toggle outside done so stale values never pass
	assign detect_valid_o = detect_done_o & {4{valid_sel_i}} | ~detect_done_o & {4{flip}};
	assign class_bad_o = ~class_done_o & {4{flip}};
endmodule

// File: tb.sv
`timescale 1ns/1ps
module tb;
	// ----------
	// stimulus and instances
	// ----------
	reg         core_clk_i = 0, reset_n_i = 0, reg_wr_i = 0, fast_off_pin_n_i = 1, vsel = 0;
	reg  [7:0]  reg_addr_i = 0, reg_wdata_i = 0, mode_i = 0;
	reg  [3:0]  power_on_cmd_i = 0, power_off_cmd_i = 0, below_dropout_i = 0, inrush_i = 0;
	reg  [3:0]  prst = 0;
	wire [7:0]  reg_rdata_o;
	wire [3:0]  detect_start_o, class_start_o, detect_done_i, detect_valid_i, class_done_i;
	wire [3:0]  class_bad_i, power_on_flag_o, dropout_fault_flag_o, cooldown_active_o;
	wire [3:0]  fault_inrush_o;
	integer     n_mismatch = 0, checked = 0, n, i, dn, cn;
	always #4 core_clk_i = ~core_clk_i;
	// short tick keeps ms timers cheap: 1 ms is 10 cycles
	pdft_core #(.TICK_CYCLES(10)) pdft_core_inst (.core_clk_i, .reset_n_i, .reg_wr_i,
		.reg_addr_i, .reg_wdata_i, .reg_rdata_o, .mode_i, .high_power_port_flag_i(4'h0),
		.cooldown_ms_i(12'h005), .auto_strap_i(1'b0), .power_on_cmd_i, .power_off_cmd_i,
		.port_reset_i(prst), .fast_off_pin_n_i, .below_dropout_i, .above_cut_i(4'h0),
		.limiting_i(inrush_i), .inrush_limiting_i(inrush_i), .drain_good_i(power_on_flag_o),
		.detect_done_i, .detect_valid_i, .class_done_i, .class_bad_i, .detect_start_o,
		.class_start_o, .power_on_flag_o, .power_good_flag_o(), .dropout_fault_flag_o,
		.cooldown_active_o, .fault_inrush_o, .fault_overload_o(), .fault_limit_o());
	pdft_eng_model pdft_eng_model_inst (.core_clk_i, .detect_start_i(detect_start_o),
		.class_start_i(class_start_o), .valid_sel_i(vsel), .detect_done_o(detect_done_i),
		.detect_valid_o(detect_valid_i), .class_done_o(class_done_i),
		.class_bad_o(class_bad_i));
	// ----------
	// tasks
	// ----------
	task tally_and_finish;
		begin
			if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
			else $display("Finished with errors");
			$finish;
		end
	endtask
	task chk(input string nm, input [7:0] e, input [7:0] g);
		begin
			checked = checked + 1;
			if (g !== e) begin
				n_mismatch = n_mismatch + 1;
				$display("[FAIL] %s exp %h got %h", nm, e, g);
			end
		end
	endtask
	// all tasks start and end just after a rising edge
	task cyc(input integer k);
		begin
			repeat (k) @(posedge core_clk_i);
			#1;
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		begin
			reg_addr_i = a;
			reg_wdata_i = d;
			reg_wr_i = 1;
			cyc(1);
			reg_wr_i = 0;
			// let an edge pass so a following write raises the strobe afresh
			cyc(1);
		end
	endtask
	task rd(input [7:0] a, input [7:0] e);
		begin
			reg_addr_i = a;
			cyc(1);
			chk("rdata", e, reg_rdata_o);
		end
	endtask
	task pulse_on;
		begin
			power_on_cmd_i = 4'h1;
			cyc(1);
			power_on_cmd_i = 4'h0;
		end
	endtask
	function sig(input integer w);
		case (w)
			0: sig = power_on_flag_o[0];
			1: sig = fault_inrush_o[0];
			2: sig = dropout_fault_flag_o[0];
			default: sig = detect_start_o[0];
		endcase
	endfunction
	// bounded wait, cycles taken left in n
	task wt(input integer w, input integer lim);
		begin
			n = 0;
			while (sig(w) !== 1'b1) begin
				if (n >= lim) begin
					chk("wait", 1, 0);
					tally_and_finish;
				end
				cyc(1);
				n = n + 1;
			end
		end
	endtask
	// ----------
	// scenarios
	// ----------
	initial begin
		cyc(2);
		reset_n_i = 1;
		cyc(4);
		for (i = 8'h13; i < 8'h17; i = i + 1) rd(i[7:0], 8'h00);
		wr(8'h17, 8'haa);
		rd(8'h17, 8'h00);
		wr(8'h13, 8'hff);
		rd(8'h13, 8'h0f);
		for (i = 1; i < 4; i = i + 1) begin
			wr(8'h16, 8'h55 * i[7:0]);
			rd(8'h16, 8'h55 * i[7:0]);
		end
		wr(8'h16, 8'h00);
		wr(8'h13, 8'h00);
		// invalid detects: repeated detection, no class
		mode_i = 8'h02;
		cyc(120);
		wr(8'h14, 8'h11);
		dn = 0;
		cn = 0;
		repeat (300) begin
			cyc(1);
			dn = dn + detect_start_o[0];
			cn = cn + class_start_o[0];
		end
		chk("semi detects", 1, dn > 1);
		chk("semi classes", 0, cn);
		vsel = 1;
		mode_i = 8'h03;
		wt(0, 400);
		power_off_cmd_i = 4'h1;
		cyc(1);
		power_off_cmd_i = 4'h0;
		cyc(1);
		chk("off", 0, power_on_flag_o[0]);
		rd(8'h14, 8'h00);
		mode_i = 8'h01;
		cyc(120);
		wr(8'h14, 8'h01);
		wt(3, 50);
		cyc(30);
		rd(8'h14, 8'h00);
		wr(8'h15, 8'h10);
		pulse_on;
		cyc(2);
		chk("on", 1, power_on_flag_o[0]);
		fast_off_pin_n_i = 0;
		cyc(5);
		chk("fast off", 0, power_on_flag_o[0]);
		fast_off_pin_n_i = 1;
		cyc(5);
		// a port reset pulse powers the port off like the fast-off path
		pulse_on;
		chk("reset on", 1, power_on_flag_o[0]);
		prst = 4'h1;
		cyc(1);
		prst = 4'h0;
		cyc(1);
		chk("port reset", 0, power_on_flag_o[0]);
		cyc(5);
		// inrush of 30 ms still limited at its end
		wr(8'h16, 8'h10);
		inrush_i = 4'h1;
		pulse_on;
		wt(1, 400);
		chk("inrush time", 1, n > 285 && n < 316);
		cyc(1);
		chk("inrush off", 0, power_on_flag_o[0]);
		chk("cooling", 1, cooldown_active_o[0]);
		inrush_i = 4'h0;
		cyc(80);
		// 60 ms inrush then 90 ms dropout
		wr(8'h16, 8'h01);
		wr(8'h13, 8'h01);
		below_dropout_i = 4'h1;
		pulse_on;
		wt(2, 2000);
		chk("dropout time", 1, n > 1475 && n < 1530);
		chk("dropout off", 0, power_on_flag_o[0]);
		tally_and_finish;
	end
endmodule
